/* File: ial_pkg.sv */
package ial_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] IAL_OFF_INSTR = 8'h00; // Write executes an op
	localparam logic [7:0] IAL_OFF_FLAGS = 8'h04; // Condition flags n,z,v,c
	localparam logic [7:0] IAL_OFF_RESULT = 8'h08; // Last computed result
	localparam logic [7:0] IAL_OFF_STATUS = 8'h0c; // Sticky trap/illegal
	localparam logic [7:0] IAL_OFF_YREG = 8'h10; // Multiply-step partner
	localparam logic [7:0] IAL_OFF_REGSEL = 8'h14; // Register file index
	localparam logic [7:0] IAL_OFF_REGDATA = 8'h18; // Register file window

	// ----------------------------------------------------------------
	// Instruction field layout
	// ----------------------------------------------------------------
	localparam int IAL_FMT_LO = 30; // Format bits 31:30
	localparam int IAL_RD_LO = 25; // Destination 29:25
	localparam int IAL_OP_LO = 19; // Operation code 24:19
	localparam int IAL_RS1_LO = 14; // First source 18:14
	localparam int IAL_ISEL_BIT = 13; // Immediate select
	localparam int IAL_RS2_LO = 0; // Second source 4:0
	localparam int IAL_IMM_W = 13; // Signed immediate width
	localparam int IAL_UPPER_W = 22; // Upper constant width
	localparam int IAL_SUB_LO = 22; // Upper-constant sub-code 24:22
	localparam logic [1:0] IAL_FMT_ARITH = 2'b10;
	localparam logic [1:0] IAL_FMT_UPPER = 2'b00;
	localparam logic [2:0] IAL_SUB_UPPER = 3'b100;

	// ----------------------------------------------------------------
	// Operation codes (flag variant = base plus bit 4)
	// ----------------------------------------------------------------
	localparam logic [5:0] IAL_OP_ADD = 6'h00;
	localparam logic [5:0] IAL_OP_AND = 6'h01;
	localparam logic [5:0] IAL_OP_OR = 6'h02;
	localparam logic [5:0] IAL_OP_XOR = 6'h03;
	localparam logic [5:0] IAL_OP_SUB = 6'h04;
	localparam logic [5:0] IAL_OP_ANDN = 6'h05;
	localparam logic [5:0] IAL_OP_ORN = 6'h06;
	localparam logic [5:0] IAL_OP_XNOR = 6'h07;
	localparam logic [5:0] IAL_OP_ADDC = 6'h08;
	localparam logic [5:0] IAL_OP_SUBC = 6'h0c;
	localparam logic [5:0] IAL_OP_ADDCC = 6'h10;
	localparam logic [5:0] IAL_OP_TSUM = 6'h20;
	localparam logic [5:0] IAL_OP_TDIF = 6'h21;
	localparam logic [5:0] IAL_OP_TSUM_TRAP = 6'h22;
	localparam logic [5:0] IAL_OP_TDIF_TRAP = 6'h23;
	localparam logic [5:0] IAL_OP_MSTEP = 6'h24;
	localparam logic [5:0] IAL_OP_SHL = 6'h25;
	localparam logic [5:0] IAL_OP_SHR = 6'h26;
	localparam logic [5:0] IAL_OP_SHRA = 6'h27;
	localparam int IAL_OP_CC_BIT = 4;

	// ----------------------------------------------------------------
	// Flag and status bit positions, reset values
	// ----------------------------------------------------------------
	localparam int IAL_FLAG_N = 3;
	localparam int IAL_FLAG_Z = 2;
	localparam int IAL_FLAG_V = 1;
	localparam int IAL_FLAG_C = 0;
	localparam int IAL_ST_TRAP = 0;
	localparam int IAL_ST_ILLEGAL = 1;
	localparam logic [3:0] IAL_FLAGS_RST = 4'h0;
	localparam logic [1:0] IAL_STATUS_RST = 2'h0;
	localparam logic [31:0] IAL_WORD_RST = 32'h0;

endpackage : ial_pkg

/* File: ial_top.sv */
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Select bit picks register or sign-extended immediate
// - Decode format 10 with fixed field positions
// - Opcode 010000 is add that sets flags
// - Flags: sign, zero, signed overflow, carry out
// - Flag-setting add replaces all four flags
// - Add with carry-in adds held carry flag
// - Opcode 001000 is add with carry-in
// - Carry-in adds finish in one cycle
// - Conjunction is bitwise product of operands
// - Opcode 000001 is plain conjunction
// - Opcode 000101 is conjunction with complement
// - Conjunction with complement takes one cycle
// - Or, or-complement, xor, xnor in one cycle
// - Upper constant loads 22 high bits
// - Shifts one cycle; arithmetic shift copies sign
// - Subtractions with optional flags, one cycle
// - Tagged ops set flags; trapping ones trap
// - Multiply step does one step, sets flags
// - Logical flag ops clear overflow and carry
module ial_top #(
	parameter int ADDR_W = 8 // APB address width
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import ial_pkg::*;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Word index of a mapped register, 4'hf when unmapped
	function automatic logic [3:0] ial_index(input logic [ADDR_W-1:0] a);
		logic [7:0] low;
		low = a[7:0];
		// Shift keeps the test legal when ADDR_W is exactly 8
		if ((a >> 8) != '0)
			return 4'hf;
		unique case (low)
			IAL_OFF_INSTR: return 4'h0;
			IAL_OFF_FLAGS: return 4'h1;
			IAL_OFF_RESULT: return 4'h2;
			IAL_OFF_STATUS: return 4'h3;
			IAL_OFF_YREG: return 4'h4;
			IAL_OFF_REGSEL: return 4'h5;
			IAL_OFF_REGDATA: return 4'h6;
			default: return 4'hf;
		endcase
	endfunction : ial_index

	// Register file read with register zero hard-wired
	function automatic logic [31:0] ial_rd_reg(input logic [31:0] rf [32],
		input logic [4:0] idx);
		return (idx == 5'h0) ? IAL_WORD_RST : rf[idx];
	endfunction : ial_rd_reg

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] rf_r [32]; // Integer register file
	logic [3:0] flags_r, flags_nxt; // n z v c
	logic [31:0] result_r, result_nxt; // Last result
	logic [1:0] status_r, status_nxt; // Sticky trap/illegal
	logic [31:0] y_r, y_nxt; // Multiply-step register
	logic [4:0] regsel_r, regsel_nxt; // Window index
	logic [31:0] prdata_r, prdata_nxt; // Read data
	logic pready_r, pready_nxt; // One wait state
	logic pslverr_r, pslverr_nxt; // Unmapped access
	logic rf_we; // Register file write strobe
	logic [4:0] rf_wa; // Register file write index
	logic [31:0] rf_wd; // Register file write data

	// ----------------------------------------------------------------
	// Bus phase decode
	// ----------------------------------------------------------------
	logic [3:0] idx; // Decoded register index
	logic done; // Access completes this edge
	logic wr_done; // Write completes this edge
	assign idx = ial_index(paddr);
	assign done = psel & penable & pready_r;
	assign wr_done = done & pwrite;

	// ----------------------------------------------------------------
	// Execution datapath
	// ----------------------------------------------------------------
	logic [1:0] fmt; // Format bits
	logic [4:0] dst; // Destination field
	logic [5:0] opc; // Operation code
	logic [4:0] first_source_field; // First source index
	logic [4:0] second_source_field; // Second source index
	logic [12:0] signed_immediate_field; // Raw immediate
	logic [31:0] opa, opb; // Operands
	logic [31:0] res; // Datapath result
	logic [3:0] cc; // Candidate flags
	logic set_cc; // Operation updates flags
	logic legal; // Recognised operation
	logic trap; // Tagged overflow trap
	logic [5:0] base; // Opcode with flag bit stripped
	logic [32:0] wide; // Sum or difference with carry
	logic cin; // Carry or borrow in
	logic sub_op; // Difference family
	logic logic_op; // Bitwise family
	logic tag_ovf; // Tag bits or overflow
	logic [31:0] mpart; // Multiply-step addend

	assign fmt = pwdata[31:IAL_FMT_LO];
	assign dst = pwdata[IAL_FMT_LO-1:IAL_RD_LO];
	assign opc = pwdata[IAL_RD_LO-1:IAL_OP_LO];
	assign first_source_field = pwdata[IAL_OP_LO-1:IAL_RS1_LO];
	assign second_source_field = pwdata[IAL_RS2_LO+4:IAL_RS2_LO];
	assign signed_immediate_field = pwdata[IAL_IMM_W-1:0];

	// Operand selection and result computation
	always_comb
	begin
		opa = ial_rd_reg(rf_r, first_source_field);
		// Bits 12:5 are ignored in the register form
		opb = pwdata[IAL_ISEL_BIT] ?
			{{(32-IAL_IMM_W){signed_immediate_field[IAL_IMM_W-1]}},
			signed_immediate_field} :
			ial_rd_reg(rf_r, second_source_field);
		// Low group: bit 4 marks the flag-setting variant
		base = opc[5] ? opc : (opc & ~6'h10);
		set_cc = opc[5] ? (opc <= IAL_OP_MSTEP) : opc[IAL_OP_CC_BIT];
		sub_op = (base == IAL_OP_SUB) || (base == IAL_OP_SUBC) ||
			(base == IAL_OP_TDIF) || (base == IAL_OP_TDIF_TRAP);
		cin = ((base == IAL_OP_ADDC) || (base == IAL_OP_SUBC)) &
			flags_r[IAL_FLAG_C];
		mpart = y_r[0] ? opb : IAL_WORD_RST;
		logic_op = 1'b0;
		legal = (fmt == IAL_FMT_ARITH);
		wide = {1'b0, opa} + {1'b0, opb} + {32'h0, cin};
		res = wide[31:0];
		unique case (base)
			IAL_OP_ADD, IAL_OP_ADDC, IAL_OP_TSUM, IAL_OP_TSUM_TRAP: ;
			IAL_OP_SUB, IAL_OP_SUBC, IAL_OP_TDIF, IAL_OP_TDIF_TRAP:
			begin
				wide = {1'b0, opa} - {1'b0, opb} - {32'h0, cin};
				res = wide[31:0];
			end
			IAL_OP_MSTEP:
			begin
				// Shift in n^v, add operand only when y bit 0 is set
				wide = {1'b0, flags_r[IAL_FLAG_N] ^ flags_r[IAL_FLAG_V],
					opa[31:1]} + {1'b0, mpart};
				res = wide[31:0];
			end
			IAL_OP_AND:
			begin
				res = opa & opb;
				logic_op = 1'b1;
			end
			IAL_OP_ANDN:
			begin
				res = opa & ~opb;
				logic_op = 1'b1;
			end
			IAL_OP_OR:
			begin
				res = opa | opb;
				logic_op = 1'b1;
			end
			IAL_OP_ORN:
			begin
				res = opa | ~opb;
				logic_op = 1'b1;
			end
			IAL_OP_XOR:
			begin
				res = opa ^ opb;
				logic_op = 1'b1;
			end
			IAL_OP_XNOR:
			begin
				res = ~(opa ^ opb);
				logic_op = 1'b1;
			end
			IAL_OP_SHL: res = opa << opb[4:0];
			IAL_OP_SHR: res = opa >> opb[4:0];
			IAL_OP_SHRA: res = $signed(opa) >>> opb[4:0];
			default: legal = 1'b0;
		endcase
		// Upper constant: 22 bits to the top, low bits cleared
		if ((fmt == IAL_FMT_UPPER) &&
			(pwdata[IAL_RD_LO-1:IAL_SUB_LO] == IAL_SUB_UPPER))
		begin
			res = {pwdata[IAL_UPPER_W-1:0], 10'h0};
			legal = 1'b1;
			set_cc = 1'b0;
			logic_op = 1'b0;
		end
		// Common flag formulas
		cc[IAL_FLAG_N] = res[31];
		cc[IAL_FLAG_Z] = (res == IAL_WORD_RST);
		if (sub_op)
		begin
			cc[IAL_FLAG_V] = (opa[31] & ~opb[31] & ~res[31]) |
				(~opa[31] & opb[31] & res[31]);
			cc[IAL_FLAG_C] = wide[32]; // Borrow out
		end
		else
		begin
			cc[IAL_FLAG_V] = (opa[31] & opb[31] & ~res[31]) |
				(~opa[31] & ~opb[31] & res[31]);
			cc[IAL_FLAG_C] = wide[32];
		end
		// Step overflow: clear when the addend's top bit is set, else the result's top bit
		if (base == IAL_OP_MSTEP)
			cc[IAL_FLAG_V] = (wide[31] ^ mpart[31] ^ res[31]) ?
				1'b0 : (res[31] ^ mpart[31]);
		// Tagged ops also overflow on nonzero tag bits
		tag_ovf = cc[IAL_FLAG_V] | (|opa[1:0]) | (|opb[1:0]);
		if (opc[5] && (base <= IAL_OP_TDIF_TRAP))
			cc[IAL_FLAG_V] = tag_ovf;
		trap = ((base == IAL_OP_TSUM_TRAP) || (base == IAL_OP_TDIF_TRAP)) &
			tag_ovf & legal & (fmt == IAL_FMT_ARITH);
		if (logic_op)
		begin
			cc[IAL_FLAG_V] = 1'b0;
			cc[IAL_FLAG_C] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register next-state logic
	// ----------------------------------------------------------------
	logic exec; // Instruction write completes
	assign exec = wr_done & (idx == 4'h0);

	// Software writes, execution effects, sticky status
	always_comb
	begin
		flags_nxt = flags_r;
		result_nxt = result_r;
		status_nxt = status_r;
		y_nxt = y_r;
		regsel_nxt = regsel_r;
		rf_we = 1'b0;
		rf_wa = dst;
		rf_wd = res;
		if (wr_done)
		begin
			unique case (idx)
				4'h1: flags_nxt = pwdata[3:0];
				4'h3: status_nxt = status_r & ~pwdata[1:0]; // Write 1 clears
				4'h4: y_nxt = pwdata;
				4'h5: regsel_nxt = pwdata[4:0];
				4'h6:
				begin
					rf_we = 1'b1;
					rf_wa = regsel_r;
					rf_wd = pwdata;
				end
				default: ;
			endcase
		end
		if (exec)
		begin
			if (!legal)
				status_nxt[IAL_ST_ILLEGAL] = 1'b1; // No state changes
			else if (trap)
				status_nxt[IAL_ST_TRAP] = 1'b1; // Trap suppresses writes
			else
			begin
				result_nxt = res;
				rf_we = 1'b1;
				if (set_cc)
					flags_nxt = cc;
				if ((opc == IAL_OP_MSTEP) && (fmt == IAL_FMT_ARITH))
					y_nxt = {opa[0], y_r[31:1]};
			end
		end
	end

	// Registers of the control state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags_r <= IAL_FLAGS_RST;
			result_r <= IAL_WORD_RST;
			status_r <= IAL_STATUS_RST;
			y_r <= IAL_WORD_RST;
			regsel_r <= 5'h0;
		end
		else
		begin
			flags_r <= flags_nxt;
			result_r <= result_nxt;
			status_r <= status_nxt;
			y_r <= y_nxt;
			regsel_r <= regsel_nxt;
		end
	end

	// Register file; writes to index zero are discarded
	always_ff @(posedge pclk)
	begin
		if (rf_we && (rf_wa != 5'h0))
			rf_r[rf_wa] <= rf_wd;
	end

	// ----------------------------------------------------------------
	// APB answer: one wait state keeps every output registered
	// ----------------------------------------------------------------
	always_comb
	begin
		pready_nxt = psel & penable & ~pready_r;
		prdata_nxt = IAL_WORD_RST;
		pslverr_nxt = 1'b0;
		if (pready_nxt)
		begin
			pslverr_nxt = (idx == 4'hf);
			if (!pwrite)
			begin
				unique case (idx)
					4'h1: prdata_nxt = {28'h0, flags_r};
					4'h2: prdata_nxt = result_r;
					4'h3: prdata_nxt = {30'h0, status_r};
					4'h4: prdata_nxt = y_r;
					4'h5: prdata_nxt = {27'h0, regsel_r};
					4'h6: prdata_nxt = ial_rd_reg(rf_r, regsel_r);
					default: prdata_nxt = IAL_WORD_RST;
				endcase
			end
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			prdata_r <= IAL_WORD_RST;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

endmodule : ial_top

/* File: ial_chk.sv */
`timescale 1ns/1ps
// ------------------------------
// Bus timing, read data and address decode checker
// ------------------------------
module ial_chk
	import ial_pkg::*;
#(
	parameter int ADDR_W = 8 // Bus address width
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase still waiting for its answer
	sequence acc_wait;
		psel && penable && !pready;
	endsequence
	// Read of the flag word completing
	sequence flag_rd;
		pready && !pwrite && paddr == IAL_OFF_FLAGS;
	endsequence
	ready_wait_a: assert property (acc_wait |=> pready)
		else $error("ready did not follow access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_cause_a: assert property (pready |-> $past(psel && penable))
		else $error("ready without access");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	flag_width_a: assert property (flag_rd |-> prdata[31:4] == 28'h0)
		else $error("flag word too wide");
	unmapped_err_a: assert property (pready && (paddr > 8'h18 ||
		paddr[1:0] != 2'b00) |-> pslverr)
		else $error("unmapped access accepted");
	mapped_ok_a: assert property (pready && paddr <= 8'h18 &&
		paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
endmodule : ial_chk

bind ial_top ial_chk #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

/* File: ial_issue.sv */
`timescale 1ns/1ps
// ------------------------------
// Issuing side: bus master model
// ------------------------------
module ial_issue (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready
);
	// Idle bus from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// One transfer; holds request until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count assumed; bench watchdog ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : ial_issue

/* File: ial_tb.sv */
`timescale 1ns/1ps
// ------------------------------
// Self-checking bench
// ------------------------------
module tb;
	import ial_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [33:0] exp_q[$]; // Check-data flag, error, data
	int err_count = 0;
	int check_count = 0;
	integer seed = 32'hfcd12895;
	logic [5:0] ops[23] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
		6'h06, 6'h07, 6'h08, 6'h0c, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14,
		6'h15, 6'h16, 6'h17, 6'h18, 6'h1c, 6'h25, 6'h26, 6'h27};
	ial_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	ial_issue i_mst (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
	// 100 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic e = 1'b0);
		exp_q.push_back({1'b0, e, 32'h0});
		i_mst.xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic e = 1'b0);
		exp_q.push_back({1'b1, e, d});
		i_mst.xfer(1'b0, a, 32'h0);
	endtask : rd
	// Reference: {flags, result}; sub carry is borrow out
	function automatic logic [35:0] calc(input logic [5:0] op,
		input logic [31:0] a, input logic [31:0] b, input logic [3:0] f);
		logic [32:0] s;
		logic [31:0] r;
		logic v, lg;
		s = 33'h0;
		lg = 1'b0;
		case (op[3:0])
			4'h0: s = a + b;
			4'h8: s = a + b + f[0];
			4'h4: s = {1'b0, a} - b;
			4'hc: s = {1'b0, a} - b - f[0];
			default: lg = 1'b1;
		endcase
		case (op[3:0])
			4'h1: r = a & b;
			4'h5: r = a & ~b;
			4'h2: r = a | b;
			4'h6: r = a | ~b;
			4'h3: r = a ^ b;
			4'h7: r = ~(a ^ b);
			default: r = s[31:0];
		endcase
		v = (op[2] ? a[31] != b[31] : a[31] == b[31]) && r[31] != a[31];
		// Separate shifts keep the arithmetic shift signed
		if (op[5] && op[1:0] == 2'b01)
			r = a << b[4:0];
		if (op[5] && op[1:0] == 2'b10)
			r = a >> b[4:0];
		if (op[5] && op[1:0] == 2'b11)
			r = $signed(a) >>> b[4:0];
		if (op[4] && !op[5])
			return {r[31], r == 0, v & !lg, s[32] & !lg, r};
		return {f, r};
	endfunction : calc
	// Oldest note is compared with each completed transfer
	always @(posedge pclk)
		if (psel && penable && pready)
		begin
			logic [33:0] e;
			e = exp_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33])
				chk(prdata, e[31:0]);
		end
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#300000;
		err_count++;
		tally_and_finish;
	end
	initial
	begin
		logic [31:0] x, y, b;
		logic [35:0] q;
		logic [3:0] f;
		logic [4:0] d;
		logic i;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(IAL_OFF_FLAGS, 32'h0);
		rd(IAL_OFF_RESULT, 32'h0);
		for (int k = 0; k < 88; k++)
		begin
			x = $random(seed);
			y = (k % 3 == 0) ? x : $random(seed);
			b = $random(seed);
			f = b[3:0];
			i = b[4];
			d = b[5] ? 5'd0 : 5'd3;
			wr(IAL_OFF_REGSEL, 32'd1);
			wr(IAL_OFF_REGDATA, x);
			wr(IAL_OFF_REGSEL, 32'd2);
			wr(IAL_OFF_REGDATA, y);
			wr(IAL_OFF_FLAGS, {28'h0, f});
			q = calc(ops[k % 23], x, i ? {{19{b[18]}}, b[18:6]} : y, f);
			wr(IAL_OFF_INSTR, {2'b10, d, ops[k % 23], 5'd1, i,
				i ? b[18:6] : 13'd2});
			rd(IAL_OFF_RESULT, q[31:0]);
			rd(IAL_OFF_FLAGS, {28'h0, q[35:32]});
			wr(IAL_OFF_REGSEL, {27'h0, d});
			rd(IAL_OFF_REGDATA, d == 0 ? 32'h0 : q[31:0]);
		end
		// Tagged sum overflows into the sign bit
		wr(IAL_OFF_REGSEL, 32'd1);
		wr(IAL_OFF_REGDATA, 32'h7fff_fffc);
		wr(IAL_OFF_REGSEL, 32'd2);
		wr(IAL_OFF_REGDATA, 32'h0000_0004);
		wr(IAL_OFF_INSTR, {2'b10, 5'd3, IAL_OP_TSUM, 5'd1, 1'b0, 13'd2});
		rd(IAL_OFF_RESULT, 32'h8000_0000);
		rd(IAL_OFF_FLAGS, 32'ha);
		// Trapping form sets trap and writes nothing
		wr(IAL_OFF_INSTR, {2'b10, 5'd0, IAL_OP_TSUM_TRAP, 5'd1, 1'b0,
			13'd2});
		rd(IAL_OFF_STATUS, 32'h1);
		rd(IAL_OFF_RESULT, 32'h8000_0000);
		wr(IAL_OFF_STATUS, 32'h1);
		// One multiply step with y bit 0 set
		wr(IAL_OFF_FLAGS, 32'h0);
		wr(IAL_OFF_YREG, 32'h1);
		wr(IAL_OFF_INSTR, {2'b10, 5'd3, IAL_OP_MSTEP, 5'd1, 1'b0, 13'd2});
		rd(IAL_OFF_RESULT, 32'h4000_0002);
		rd(IAL_OFF_FLAGS, 32'h0);
		rd(IAL_OFF_YREG, 32'h0);
		wr(IAL_OFF_INSTR, {2'b00, 5'd3, 3'b100, b[21:0]});
		rd(IAL_OFF_RESULT, {b[21:0], 10'h0});
		wr(IAL_OFF_INSTR, 32'hc000_0000);
		rd(IAL_OFF_STATUS, 32'h2);
		wr(IAL_OFF_STATUS, 32'h2);
		rd(IAL_OFF_STATUS, 32'h0);
		wr(8'h40, x, 1'b1);
		rd(8'h40, 32'h0, 1'b1);
		repeat (2) @(posedge pclk);
		// Every noted transfer must have completed
		chk(exp_q.size(), 32'h0);
		tally_and_finish;
	end
endmodule : tb
